//--- logic/bidr_cfg.svh
// constants for the bridge i/o, legacy display and remap decoder
`ifndef BIDR_CFG_SVH
`define BIDR_CFG_SVH
// register byte offsets
`define BIDR_CTRL_OFS 8'h00
`define BIDR_IOBASE_OFS 8'h04
`define BIDR_IOLIM_OFS 8'h08
`define BIDR_NPBASE_OFS 8'h0c
`define BIDR_NPLIM_OFS 8'h10
`define BIDR_NPREMAP_OFS 8'h14
`define BIDR_PFBASE_LO_OFS 8'h18
`define BIDR_PFBASE_HI_OFS 8'h1c
`define BIDR_PFLIM_LO_OFS 8'h20
`define BIDR_PFLIM_HI_OFS 8'h24
`define BIDR_PFREMAP_LO_OFS 8'h28
`define BIDR_PFREMAP_HI_OFS 8'h2c
`define BIDR_STATUS_OFS 8'h30
// control register bit positions
`define BIDR_CTRL_IO_EN 0
`define BIDR_CTRL_MEM_EN 1
`define BIDR_CTRL_BM_EN 2
`define BIDR_CTRL_ISA_EN 3
`define BIDR_CTRL_DISP_EN 4
`define BIDR_CTRL_DISP_FULL 5
`define BIDR_CTRL_SNOOP 6
`define BIDR_CTRL_MASK 32'h0000003f
// legacy display ranges
`define BIDR_DISP_MEM_LO 32'h000a0000
`define BIDR_DISP_MEM_HI 32'h000bffff
`define BIDR_DISP_IO_A_LO 16'h03b0
`define BIDR_DISP_IO_A_HI 16'h03bb
`define BIDR_DISP_IO_B_LO 16'h03c0
`define BIDR_DISP_IO_B_HI 16'h03df
// isa alias: low 256 bytes of each 1 kb block pass, below 64 kb
`define BIDR_ISA_LIMIT 32'h0000ffff
// window granules: i/o 4 kb, memory 1 mb
`define BIDR_IO_GRAN_BITS 12
`define BIDR_MEM_GRAN_BITS 20
`endif

//--- logic/bidr_pkg.sv
// types for the bridge i/o, legacy display and remap decoder
package bidr_pkg;
  // request kind seen by the decoder
  typedef enum logic [1:0] {
    BIDR_REQ_IO,
    BIDR_REQ_MEM32,
    BIDR_REQ_MEM64
  } bidr_kind_t;
  // routing verdict
  typedef enum logic [2:0] {
    BIDR_RT_NONE,
    BIDR_RT_DOWN,
    BIDR_RT_UP,
    BIDR_RT_UR,
    BIDR_RT_IGNORE
  } bidr_route_t;
endpackage

//--- logic/bidr_decode.sv
// i/o window, isa alias, legacy display and downstream remap decoder
`include "bidr_cfg.svh"

// How it works
// - upstream pci i/o only with bus master
// - isa mode blocks upper 768 bytes downstream
// - isa off forwards whole i/o window
// - above 64 kb only window compare
// - isa aliases go upstream even inside window
// - outside window goes up, inside stays
// - i/o window 4 kb aligned and sized
// - downstream i/o when base not above limit
// - display enable claims down, blocks up
// - display memory 0xa0000 to 0xbffff
// - ten-bit display i/o decode by default
// - sixteen-bit display i/o decode when selected
// - palette snoop reads zero, ignores writes
// - isa filter only inside window, below 64k
// - isa mode affects i/o decode only
// - primary windows claim, offset by base difference
// - nonprefetch address remapped by base difference
// - prefetch 64-bit address remapped likewise
// - i/o disabled: none down (ur), all up except display i/o
// - combined base above limit disables window
module bidr_decode
  import bidr_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // request from the pcie side (downstream direction)
  input wire logic dn_valid_in,
  input wire bidr_kind_t dn_kind_in,
  input wire logic [63:0] dn_addr_in,
  // request seen on the pci bus (upstream direction)
  input wire logic up_valid_in,
  input wire bidr_kind_t up_kind_in,
  input wire logic [63:0] up_addr_in,
  // verdicts, registered one cycle after the request
  output logic dn_valid_out,
  output bidr_route_t dn_route_out,
  output logic [63:0] dn_addr_out,
  output logic up_valid_out,
  output bidr_route_t up_route_out
);

  // configuration state
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] io_base_reg, io_base_next; // bits 31:12 kept
  logic [31:0] io_lim_reg, io_lim_next;
  logic [31:0] np_base_reg, np_base_next; // bits 31:20 kept
  logic [31:0] np_lim_reg, np_lim_next;
  logic [31:0] np_remap_reg, np_remap_next;
  logic [63:0] pf_base_reg, pf_base_next;
  logic [63:0] pf_lim_reg, pf_lim_next;
  logic [63:0] pf_remap_reg, pf_remap_next;
  logic [31:0] rdata_reg, rdata_next;
  // decision outputs
  logic dn_v_reg, dn_v_next;
  bidr_route_t dn_rt_reg, dn_rt_next;
  logic [63:0] dn_a_reg, dn_a_next;
  logic up_v_reg, up_v_next;
  bidr_route_t up_rt_reg, up_rt_next;
  // status: counts of decided requests, wrapping
  logic [15:0] dn_cnt_reg, dn_cnt_next;
  logic [15:0] up_cnt_reg, up_cnt_next;

  // control bits
  logic io_en, mem_en, bm_en, isa_en, disp_en, disp_full;
  assign io_en = ctrl_reg[`BIDR_CTRL_IO_EN];
  assign mem_en = ctrl_reg[`BIDR_CTRL_MEM_EN];
  assign bm_en = ctrl_reg[`BIDR_CTRL_BM_EN];
  assign isa_en = ctrl_reg[`BIDR_CTRL_ISA_EN];
  assign disp_en = ctrl_reg[`BIDR_CTRL_DISP_EN];
  assign disp_full = ctrl_reg[`BIDR_CTRL_DISP_FULL];

  // window validity; whole 32/64-bit values compared
  logic io_win_on, np_win_on, pf_win_on;
  assign io_win_on = io_base_reg <= io_lim_reg;
  assign np_win_on = np_base_reg <= np_lim_reg;
  assign pf_win_on = pf_base_reg <= pf_lim_reg;

  // offsets between the two buses, modular
  logic [31:0] nonprefetch_base_offset;
  logic [63:0] prefetch_base_offset;
  assign nonprefetch_base_offset = np_base_reg - np_remap_reg;
  assign prefetch_base_offset = pf_base_reg - pf_remap_reg;

  // i/o window hit: low 12 bits implied 000 / fff
  function automatic logic io_hit(input logic [63:0] a);
    logic [31:0] lo;
    lo = a[31:0];
    // limit covers its whole 4 kb granule
    io_hit = io_win_on && (a[63:32] == 32'h0) &&
      (lo >= io_base_reg) &&
      (lo <= {io_lim_reg[31:`BIDR_IO_GRAN_BITS], 12'hfff});
  endfunction

  // isa alias: below 64 kb and in the upper 768 of a 1 kb block
  function automatic logic isa_alias(input logic [63:0] a);
    isa_alias = (a <= {32'h0, `BIDR_ISA_LIMIT}) && (a[9:8] != 2'b00);
  endfunction

  // legacy display i/o match
  function automatic logic disp_io(input logic [63:0] a);
    logic [15:0] k;
    k = disp_full ? a[15:0] : {6'h00, a[9:0]};
    // full compare also needs upper bits zero
    disp_io = disp_en && (!disp_full || a[63:16] == 48'h0) &&
      ((k >= `BIDR_DISP_IO_A_LO && k <= `BIDR_DISP_IO_A_HI) ||
       (k >= `BIDR_DISP_IO_B_LO && k <= `BIDR_DISP_IO_B_HI));
  endfunction

  // legacy frame buffer match
  function automatic logic disp_mem(input logic [63:0] a);
    disp_mem = disp_en && (a >= {32'h0, `BIDR_DISP_MEM_LO}) &&
      (a <= {32'h0, `BIDR_DISP_MEM_HI});
  endfunction

  function automatic logic np_hit(input logic [63:0] a);
    np_hit = np_win_on && (a[63:32] == 32'h0) &&
      (a[31:0] >= np_base_reg) &&
      (a[31:0] <= {np_lim_reg[31:`BIDR_MEM_GRAN_BITS], 20'hfffff});
  endfunction

  function automatic logic pf_hit(input logic [63:0] a);
    pf_hit = pf_win_on && (a >= pf_base_reg) &&
      (a <= {pf_lim_reg[63:`BIDR_MEM_GRAN_BITS], 20'hfffff});
  endfunction

  // register writes and reads
  always_comb
  begin
    ctrl_next = ctrl_reg;
    io_base_next = io_base_reg;
    io_lim_next = io_lim_reg;
    np_base_next = np_base_reg;
    np_lim_next = np_lim_reg;
    np_remap_next = np_remap_reg;
    pf_base_next = pf_base_reg;
    pf_lim_next = pf_lim_reg;
    pf_remap_next = pf_remap_reg;
    rdata_next = 32'h0;
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        // snoop bit masked off, writes dropped
        `BIDR_CTRL_OFS: ctrl_next = reg_wdata_in & `BIDR_CTRL_MASK;
        // low 12 bits of i/o, low 20 bits of memory forced to zero
        `BIDR_IOBASE_OFS: io_base_next = {reg_wdata_in[31:12], 12'h000};
        `BIDR_IOLIM_OFS: io_lim_next = {reg_wdata_in[31:12], 12'h000};
        `BIDR_NPBASE_OFS: np_base_next = {reg_wdata_in[31:20], 20'h0};
        `BIDR_NPLIM_OFS: np_lim_next = {reg_wdata_in[31:20], 20'h0};
        // remap bases writable at any time
        `BIDR_NPREMAP_OFS: np_remap_next = {reg_wdata_in[31:20], 20'h0};
        `BIDR_PFBASE_LO_OFS:
          pf_base_next[31:0] = {reg_wdata_in[31:20], 20'h0};
        `BIDR_PFBASE_HI_OFS: pf_base_next[63:32] = reg_wdata_in;
        `BIDR_PFLIM_LO_OFS:
          pf_lim_next[31:0] = {reg_wdata_in[31:20], 20'h0};
        `BIDR_PFLIM_HI_OFS: pf_lim_next[63:32] = reg_wdata_in;
        `BIDR_PFREMAP_LO_OFS:
          pf_remap_next[31:0] = {reg_wdata_in[31:20], 20'h0};
        `BIDR_PFREMAP_HI_OFS: pf_remap_next[63:32] = reg_wdata_in;
        // read-only or unmapped: ignored
        default: ;
      endcase
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `BIDR_CTRL_OFS: rdata_next = ctrl_reg;
        `BIDR_IOBASE_OFS: rdata_next = io_base_reg;
        `BIDR_IOLIM_OFS: rdata_next = io_lim_reg;
        `BIDR_NPBASE_OFS: rdata_next = np_base_reg;
        `BIDR_NPLIM_OFS: rdata_next = np_lim_reg;
        `BIDR_NPREMAP_OFS: rdata_next = np_remap_reg;
        `BIDR_PFBASE_LO_OFS: rdata_next = pf_base_reg[31:0];
        `BIDR_PFBASE_HI_OFS: rdata_next = pf_base_reg[63:32];
        `BIDR_PFLIM_LO_OFS: rdata_next = pf_lim_reg[31:0];
        `BIDR_PFLIM_HI_OFS: rdata_next = pf_lim_reg[63:32];
        `BIDR_PFREMAP_LO_OFS: rdata_next = pf_remap_reg[31:0];
        `BIDR_PFREMAP_HI_OFS: rdata_next = pf_remap_reg[63:32];
        // status: window states and request counts
        `BIDR_STATUS_OFS:
          rdata_next = {up_cnt_reg[12:0], dn_cnt_reg[12:0], 3'b000,
            pf_win_on, np_win_on, io_win_on};
        // unmapped reads return zero
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // downstream decision, pcie to pci
  always_comb
  begin
    dn_v_next = dn_valid_in;
    dn_rt_next = BIDR_RT_NONE;
    dn_a_next = dn_addr_in;
    dn_cnt_next = dn_cnt_reg + {15'h0, dn_valid_in};
    if (dn_valid_in)
    begin
      case (dn_kind_in)
        BIDR_REQ_IO:
        begin
          if (!io_en)
            dn_rt_next = BIDR_RT_UR;
          else if (disp_io(dn_addr_in))
            dn_rt_next = BIDR_RT_DOWN;
          else if (isa_en && io_hit(dn_addr_in) && isa_alias(dn_addr_in))
            dn_rt_next = BIDR_RT_NONE;
          else if (io_hit(dn_addr_in))
            dn_rt_next = BIDR_RT_DOWN;
          else
            dn_rt_next = BIDR_RT_NONE;
        end
        BIDR_REQ_MEM32, BIDR_REQ_MEM64:
        begin
          // isa mode plays no part here
          if (!mem_en)
            dn_rt_next = BIDR_RT_UR;
          else if (disp_mem(dn_addr_in))
            dn_rt_next = BIDR_RT_DOWN;
          else if (np_hit(dn_addr_in))
          begin
            dn_rt_next = BIDR_RT_DOWN;
            dn_a_next = {32'h0,
              dn_addr_in[31:0] - nonprefetch_base_offset};
          end
          else if (pf_hit(dn_addr_in))
          begin
            dn_rt_next = BIDR_RT_DOWN;
            dn_a_next = dn_addr_in - prefetch_base_offset;
          end
          else
            dn_rt_next = BIDR_RT_NONE;
        end
        default: dn_rt_next = BIDR_RT_NONE;
      endcase
    end
  end

  // upstream decision, pci to pcie
  always_comb
  begin
    up_v_next = up_valid_in;
    up_rt_next = BIDR_RT_NONE;
    up_cnt_next = up_cnt_reg + {15'h0, up_valid_in};
    if (up_valid_in)
    begin
      if (!bm_en)
        up_rt_next = BIDR_RT_IGNORE;
      else
      begin
        case (up_kind_in)
          BIDR_REQ_IO:
          begin
            if (disp_io(up_addr_in))
              up_rt_next = BIDR_RT_NONE;
            else if (!io_en)
              up_rt_next = BIDR_RT_UP;
            // isa alias goes up inside window
            else if (isa_en && io_hit(up_addr_in) &&
                isa_alias(up_addr_in))
              up_rt_next = BIDR_RT_UP;
            else if (io_hit(up_addr_in))
              up_rt_next = BIDR_RT_NONE;
            else
              up_rt_next = BIDR_RT_UP;
          end
          BIDR_REQ_MEM32, BIDR_REQ_MEM64:
          begin
            // memory inverse decode on primary windows
            if (disp_mem(up_addr_in))
              up_rt_next = BIDR_RT_NONE;
            else if (!mem_en)
              up_rt_next = BIDR_RT_UP;
            else if (np_hit(up_addr_in) || pf_hit(up_addr_in))
              up_rt_next = BIDR_RT_NONE;
            else
              up_rt_next = BIDR_RT_UP;
          end
          default: up_rt_next = BIDR_RT_NONE;
        endcase
      end
    end
  end

  // state registers
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ctrl_reg <= 32'h0;
      io_base_reg <= 32'h0;
      io_lim_reg <= 32'h0;
      np_base_reg <= 32'h0;
      np_lim_reg <= 32'h0;
      np_remap_reg <= 32'h0;
      pf_base_reg <= 64'h0;
      pf_lim_reg <= 64'h0;
      pf_remap_reg <= 64'h0;
      rdata_reg <= 32'h0;
      dn_v_reg <= 1'b0;
      dn_rt_reg <= BIDR_RT_NONE;
      dn_a_reg <= 64'h0;
      up_v_reg <= 1'b0;
      up_rt_reg <= BIDR_RT_NONE;
      dn_cnt_reg <= 16'h0;
      up_cnt_reg <= 16'h0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      io_base_reg <= io_base_next;
      io_lim_reg <= io_lim_next;
      np_base_reg <= np_base_next;
      np_lim_reg <= np_lim_next;
      np_remap_reg <= np_remap_next;
      pf_base_reg <= pf_base_next;
      pf_lim_reg <= pf_lim_next;
      pf_remap_reg <= pf_remap_next;
      rdata_reg <= rdata_next;
      dn_v_reg <= dn_v_next;
      dn_rt_reg <= dn_rt_next;
      dn_a_reg <= dn_a_next;
      up_v_reg <= up_v_next;
      up_rt_reg <= up_rt_next;
      dn_cnt_reg <= dn_cnt_next;
      up_cnt_reg <= up_cnt_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata_out = rdata_reg;
  assign dn_valid_out = dn_v_reg;
  assign dn_route_out = dn_rt_reg;
  assign dn_addr_out = dn_a_reg;
  assign up_valid_out = up_v_reg;
  assign up_route_out = up_rt_reg;

endmodule

//--- sim/bidr_decode_chk.sv
// port checker for the bridge i/o, display and remap decoder
module bidr_decode_chk
  import bidr_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // decode paths
  input wire logic dn_valid_in,
  input wire bidr_kind_t dn_kind_in,
  input wire logic [63:0] dn_addr_in,
  input wire logic up_valid_in,
  input wire bidr_kind_t up_kind_in,
  input wire logic dn_valid_out,
  input wire bidr_route_t dn_route_out,
  input wire logic up_valid_out,
  input wire bidr_route_t up_route_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // mirror of the writable control bits
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  // mirror follows writes to the control word
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (reg_wr_in && reg_addr_in == 8'h00)
    begin
      ctrl_next = reg_wdata_in[5:0];
    end
  end
  // register the mirror, cleared by reset like the design
  always_ff @(posedge clock_in)
  begin
    ctrl_reg <= rst_in ? 6'h00 : ctrl_next;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // a read strobe on the control word
  sequence ctrl_read;
    reg_rd_in && reg_addr_in == 8'h00;
  endsequence
  // a display frame buffer access from the link side
  sequence disp_mem_req;
    dn_valid_in && dn_kind_in == BIDR_REQ_MEM32 && ctrl_reg[1]
      && ctrl_reg[4] && dn_addr_in inside {[64'h a0000:64'h bffff]};
  endsequence
  ctrl_read_a: assert property (ctrl_read |=>
    reg_rdata_out == {26'h0, ctrl_reg}) else $error("ctrl readback");
  rdata_idle_a: assert property (!reg_rd_in |=>
    reg_rdata_out == 32'h0) else $error("read data not idle");
  dn_track_a: assert property (
    dn_valid_out == $past(dn_valid_in)) else $error("dn answer");
  up_track_a: assert property (
    up_valid_out == $past(up_valid_in)) else $error("up answer");
  io_off_ur_a: assert property (dn_valid_in && !ctrl_reg[0]
    && dn_kind_in == BIDR_REQ_IO |=> dn_route_out == BIDR_RT_UR)
    else $error("io off not ur");
  io_off_up_a: assert property (up_valid_in && !ctrl_reg[0]
    && ctrl_reg[2] && !ctrl_reg[4] && up_kind_in == BIDR_REQ_IO
    |=> up_route_out == BIDR_RT_UP) else $error("io off not up");
  bm_off_a: assert property (up_valid_in && !ctrl_reg[2]
    |=> up_route_out == BIDR_RT_IGNORE) else $error("bm off");
  disp_mem_a: assert property (disp_mem_req |=>
    dn_route_out == BIDR_RT_DOWN) else $error("display mem");
endmodule

bind bidr_decode bidr_decode_chk i_chk (
  .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .dn_valid_in(dn_valid_in), .dn_kind_in(dn_kind_in),
  .dn_addr_in(dn_addr_in), .up_valid_in(up_valid_in),
  .up_kind_in(up_kind_in), .dn_valid_out(dn_valid_out),
  .dn_route_out(dn_route_out), .up_valid_out(up_valid_out),
  .up_route_out(up_route_out));

//--- sim/bidr_far_model.sv
// far-side requester: one request pulse per command from the bench
module bidr_far_model
  import bidr_pkg::*;
(
  // clock and command
  input wire logic clock_in,
  input wire logic go_in,
  input wire bidr_kind_t kind_in,
  input wire logic [63:0] addr_in,
  // request toward the decoder
  output logic valid_out,
  output bidr_kind_t kind_out,
  output logic [63:0] addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic valid_reg = 1'b0;
  logic valid_next;
  bidr_kind_t kind_reg = BIDR_REQ_IO;
  bidr_kind_t kind_next;
  logic [63:0] addr_reg = 64'h0;
  logic [63:0] addr_next;
  // idle address flips each cycle so a stale value never looks valid
  always_comb
  begin
    valid_next = go_in;
    kind_next = go_in ? kind_in : kind_reg;
    addr_next = go_in ? addr_in : ~addr_reg;
  end
  // request registers
  always_ff @(posedge clock_in)
  begin
    valid_reg <= valid_next;
    kind_reg <= kind_next;
    addr_reg <= addr_next;
  end
  assign valid_out = valid_reg;
  assign kind_out = kind_reg;
  assign addr_out = addr_reg;
endmodule

//--- sim/bridge_io_legacy_decode_remap_test.sv
// self-checking bench for the bridge decoder
`include "bidr_cfg.svh"
module bridge_io_legacy_decode_remap_test
  import bidr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, rst_in, wr_s, rd_s, dn_go, up_go;
  logic [7:0] ra;
  logic [31:0] wd, rdata;
  bidr_kind_t dk, uk, dkw, ukw;
  logic [63:0] da, ua, daw, uaw, dn_addr_out;
  logic dvw, uvw, dn_valid_out, up_valid_out;
  bidr_route_t dn_route_out, up_route_out;
  int fail_count = 0;
  int checks = 0;
  bidr_far_model i_rc (.clock_in(clock_in), .go_in(dn_go),
    .kind_in(dk), .addr_in(da), .valid_out(dvw), .kind_out(dkw),
    .addr_out(daw));
  bidr_far_model i_agent (.clock_in(clock_in), .go_in(up_go),
    .kind_in(uk), .addr_in(ua), .valid_out(uvw), .kind_out(ukw),
    .addr_out(uaw));
  bidr_decode i_dut (.clock_in(clock_in), .rst_in(rst_in),
    .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdata), .dn_valid_in(dvw),
    .dn_kind_in(dkw), .dn_addr_in(daw), .up_valid_in(uvw),
    .up_kind_in(ukw), .up_addr_in(uaw), .dn_valid_out(dn_valid_out),
    .dn_route_out(dn_route_out), .dn_addr_out(dn_addr_out),
    .up_valid_out(up_valid_out), .up_route_out(up_route_out));
  // free-running core clock
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // compare one value and count it
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask
  // read strobe, data looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 chk(64'(rdata), 64'(e));
  endtask
  // link-side request through the root complex model
  task automatic dn(input bidr_kind_t k, input logic [63:0] a,
    input bidr_route_t r, input logic [63:0] e);
    @(posedge clock_in);
    dn_go <= 1'b1;
    dk <= k;
    da <= a;
    @(posedge clock_in);
    dn_go <= 1'b0;
    @(posedge clock_in);
    #1 chk(64'(dn_valid_out), 64'h1);
    chk(64'(dn_route_out), 64'(r));
    chk(dn_addr_out, e);
  endtask
  // bus-side request through the agent model
  task automatic up(input bidr_kind_t k, input logic [63:0] a,
    input bidr_route_t r);
    @(posedge clock_in);
    up_go <= 1'b1;
    uk <= k;
    ua <= a;
    @(posedge clock_in);
    up_go <= 1'b0;
    @(posedge clock_in);
    #1 chk(64'(up_valid_out), 64'h1);
    chk(64'(up_route_out), 64'(r));
  endtask
  // reset values, read-only snoop bit, unmapped place, 4 kb granule
  task automatic t_regs();
    // base 0 and limit 0 still make open windows, no counts yet
    rd(`BIDR_STATUS_OFS, 32'h7);
    rd(`BIDR_CTRL_OFS, 32'h0);
    wr(`BIDR_CTRL_OFS, 32'hffffffff);
    rd(`BIDR_CTRL_OFS, 32'h3f);
    rd(8'hfc, 32'h0);
    wr(`BIDR_IOBASE_OFS, 32'h1234);
    rd(`BIDR_IOBASE_OFS, 32'h1000);
  endtask
  // window, isa alias, above 64 kb, inverted window
  task automatic t_io();
    wr(`BIDR_CTRL_OFS, 32'h07);
    wr(`BIDR_IOLIM_OFS, 32'h1000);
    dn(BIDR_REQ_IO, 64'h1fff, BIDR_RT_DOWN, 64'h1fff);
    dn(BIDR_REQ_IO, 64'h2000, BIDR_RT_NONE, 64'h2000);
    dn(BIDR_REQ_IO, 64'h1100, BIDR_RT_DOWN, 64'h1100);
    up(BIDR_REQ_IO, 64'h1100, BIDR_RT_NONE);
    up(BIDR_REQ_IO, 64'h3000, BIDR_RT_UP);
    wr(`BIDR_CTRL_OFS, 32'h0f);
    dn(BIDR_REQ_IO, 64'h1100, BIDR_RT_NONE, 64'h1100);
    dn(BIDR_REQ_IO, 64'h1cff, BIDR_RT_DOWN, 64'h1cff);
    up(BIDR_REQ_IO, 64'h1100, BIDR_RT_UP);
    up(BIDR_REQ_IO, 64'h10ff, BIDR_RT_NONE);
    wr(`BIDR_IOBASE_OFS, 32'h21000);
    wr(`BIDR_IOLIM_OFS, 32'h21000);
    dn(BIDR_REQ_IO, 64'h21100, BIDR_RT_DOWN, 64'h21100);
    up(BIDR_REQ_IO, 64'h21100, BIDR_RT_NONE);
    wr(`BIDR_IOLIM_OFS, 32'h20000);
    dn(BIDR_REQ_IO, 64'h21000, BIDR_RT_NONE, 64'h21000);
  endtask
  // i/o space off, then bus master off
  task automatic t_off();
    wr(`BIDR_IOLIM_OFS, 32'h21000);
    wr(`BIDR_CTRL_OFS, 32'h06);
    dn(BIDR_REQ_IO, 64'h21100, BIDR_RT_UR, 64'h21100);
    up(BIDR_REQ_IO, 64'h21100, BIDR_RT_UP);
    wr(`BIDR_CTRL_OFS, 32'h03);
    up(BIDR_REQ_IO, 64'h5000, BIDR_RT_IGNORE);
    wr(`BIDR_IOLIM_OFS, 32'h0);
  endtask
  // legacy display memory and both i/o decode widths
  task automatic t_disp();
    // close both memory windows, base above limit, so only display claims
    wr(`BIDR_NPBASE_OFS, 32'h00100000);
    wr(`BIDR_PFBASE_HI_OFS, 32'h1);
    wr(`BIDR_CTRL_OFS, 32'h17);
    dn(BIDR_REQ_MEM32, 64'h9ffff, BIDR_RT_NONE, 64'h9ffff);
    dn(BIDR_REQ_MEM32, 64'ha0000, BIDR_RT_DOWN, 64'ha0000);
    dn(BIDR_REQ_MEM32, 64'hbffff, BIDR_RT_DOWN, 64'hbffff);
    dn(BIDR_REQ_MEM32, 64'hc0000, BIDR_RT_NONE, 64'hc0000);
    up(BIDR_REQ_MEM32, 64'ha0000, BIDR_RT_NONE);
    up(BIDR_REQ_MEM32, 64'hc0000, BIDR_RT_UP);
    dn(BIDR_REQ_IO, 64'h13b0, BIDR_RT_DOWN, 64'h13b0);
    dn(BIDR_REQ_IO, 64'h3bc, BIDR_RT_NONE, 64'h3bc);
    wr(`BIDR_CTRL_OFS, 32'h37);
    dn(BIDR_REQ_IO, 64'h13b0, BIDR_RT_NONE, 64'h13b0);
    dn(BIDR_REQ_IO, 64'h3df, BIDR_RT_DOWN, 64'h3df);
  endtask
  // remap bases first, then enable; isa left on on purpose
  task automatic t_remap();
    wr(`BIDR_CTRL_OFS, 32'h0);
    wr(`BIDR_NPREMAP_OFS, 32'h80000000);
    wr(`BIDR_NPBASE_OFS, 32'h10000000);
    wr(`BIDR_NPLIM_OFS, 32'h10000000);
    wr(`BIDR_PFREMAP_LO_OFS, 32'h40000000);
    wr(`BIDR_PFBASE_HI_OFS, 32'h1);
    wr(`BIDR_PFLIM_HI_OFS, 32'h1);
    wr(`BIDR_CTRL_OFS, 32'h0f);
    dn(BIDR_REQ_MEM32, 64'h10001234, BIDR_RT_DOWN, 64'h80001234);
    dn(BIDR_REQ_MEM32, 64'h100fffff, BIDR_RT_DOWN, 64'h800fffff);
    dn(BIDR_REQ_MEM32, 64'h10100000, BIDR_RT_NONE, 64'h10100000);
    dn(BIDR_REQ_MEM64, 64'h1000ffff0, BIDR_RT_DOWN, 64'h400ffff0);
    wr(`BIDR_PFREMAP_LO_OFS, 32'hfff00000);
    wr(`BIDR_PFREMAP_HI_OFS, 32'hffffffff);
    dn(BIDR_REQ_MEM64, 64'h100000010, BIDR_RT_DOWN,
      64'hfffffffffff00010);
  endtask
  // closing report
  task automatic give_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst_in = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    ra = 8'h00;
    wd = 32'h0;
    dn_go = 1'b0;
    up_go = 1'b0;
    dk = BIDR_REQ_IO;
    uk = BIDR_REQ_IO;
    da = 64'h0;
    ua = 64'h0;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    t_regs();
    t_io();
    t_off();
    t_disp();
    t_remap();
    give_verdict();
  end
endmodule
